/* mcu_ctrl_pkg.sv */
// package: register map, fields, reset values and timing of the mcu control block
package mcu_ctrl_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] MCU_CONTROL_OFS = 8'h35; // index, byte address is four times
  localparam logic [7:0] IRQ_CONTROL_OFS = 8'h36; // mask bits and global enable
  localparam logic [7:0] CORE_STATUS_OFS = 8'h37; // sleep state and pin requests
  localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
  localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;

  // ****************************************
  // fields of mcu_control
  // ****************************************
  localparam int EXT_MEM_ENABLE_BIT = 7;
  localparam int EXT_MEM_WAIT_STATE_BIT = 6;
  localparam int SLEEP_ALLOW_BIT = 5;
  localparam int SLEEP_SELECT_BIT = 4;
  localparam int EXT_IRQ1_PIN_SENSE_LSB = 2;
  localparam int EXT_IRQ0_PIN_SENSE_LSB = 0;

  // ****************************************
  // fields of irq_control (general_irq_mask bits and global enable)
  // ****************************************
  localparam int IRQ0_MASK_BIT = 0;
  localparam int IRQ1_MASK_BIT = 1;
  localparam int GLOBAL_IRQ_BIT = 7;

  // ****************************************
  // sense encodings and timing
  // ****************************************
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_RSVD = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  localparam int MEM_BASE_CYCLES = 3;
  localparam int MEM_WAIT_CYCLES = 1;
  localparam int CLK_MHZ = 125;
  localparam int RESET_TIMEOUT_US = 16; // start-up delay after power-down wake
  localparam int RESET_TIMEOUT_CYC = RESET_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IDLE = 2'b01,
    ST_PDOWN = 2'b10,
    ST_START = 2'b11
  } sleep_state_t;

endpackage : mcu_ctrl_pkg

/* ext_irq_sense.sv */
// one external interrupt pin: sampling, sense decode and request
module ext_irq_sense
  import mcu_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  input wire logic [1:0] sense,
  output logic req,
  output logic level_low
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic req;
  } sense_st_t;

  sense_st_t st_q;
  sense_st_t st_d;

  // two-stage sample, edge from stage two only, request per sense code
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.prev = st_q.s2;
    case (sense)
      SENSE_LOW: st_d.req = ~st_q.s2; // not latched, follows pin
      SENSE_FALL: st_d.req = st_q.prev & ~st_q.s2;
      SENSE_RISE: st_d.req = ~st_q.prev & st_q.s2;
      default: st_d.req = 1'b0; // reserved code
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, req: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign req = st_q.req;
  assign level_low = ~st_q.s2;

endmodule : ext_irq_sense

/* mcu_control_sleep.sv */
// mcu control register, sleep control and external interrupt requests
module mcu_control_sleep
  import mcu_ctrl_pkg::*;
#(
  parameter int RESET_TIMEOUT = RESET_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  input wire logic sleep_instr,
  input wire logic watchdog_reset,
  input wire logic timer_irq,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  output logic ext_mem_enable,
  output logic ext_mem_wait_state,
  output logic [2:0] mem_access_cycles,
  output logic [1:0] ext_irq_req,
  output logic cpu_halt,
  output logic osc_stop,
  output logic wake_reset,
  output logic [1:0] sleep_state
);

  import mcu_ctrl_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] mcu_control;
    logic [7:0] irq_control;
    logic [31:0] rdata;
    logic ack;
    logic [1:0] resp;
    sleep_state_t sst;
    logic [31:0] start_cnt;
    logic [1:0] irq_req;
    logic wake_rst;
    logic [2:0] cycles;
  } top_st_t;

  top_st_t st_q;
  top_st_t st_d;
  logic [1:0] pin_req;
  logic [1:0] pin_low;
  logic [1:0] irq_en;
  logic bus_req;
  logic [7:0] word_idx;

  // word index of a byte address
  function automatic logic [7:0] word_of(input logic [7:0] a);
    word_of = {2'h0, a[7:2]};
  endfunction : word_of

  // access length for a given wait state setting
  function automatic logic [2:0] access_len(input logic ws);
    access_len = ws ? 3'(MEM_BASE_CYCLES + MEM_WAIT_CYCLES) : 3'(MEM_BASE_CYCLES);
  endfunction : access_len

  // ****************************************
  // pin sense units
  // ****************************************
  // pins are read whatever their direction, so output pins trigger too
  ext_irq_sense u_irq0 (
    .clk(clk),
    .nrst(nrst),
    .pin(ext_irq0_pin),
    .sense(st_q.mcu_control[EXT_IRQ0_PIN_SENSE_LSB +: 2]),
    .req(pin_req[0]),
    .level_low(pin_low[0])
  );

  ext_irq_sense u_irq1 (
    .clk(clk),
    .nrst(nrst),
    .pin(ext_irq1_pin),
    .sense(st_q.mcu_control[EXT_IRQ1_PIN_SENSE_LSB +: 2]),
    .req(pin_req[1]),
    .level_low(pin_low[1])
  );

  // mask and global enable gating
  assign irq_en[0] = st_q.irq_control[GLOBAL_IRQ_BIT] & st_q.irq_control[IRQ0_MASK_BIT];
  assign irq_en[1] = st_q.irq_control[GLOBAL_IRQ_BIT] & st_q.irq_control[IRQ1_MASK_BIT];
  assign bus_req = (read | write) & ~st_q.ack;
  assign word_idx = word_of(address);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic level_wake;
    logic any_irq;
    level_wake = 1'b0;
    any_irq = 1'b0;
    st_d = st_q;
    st_d.ack = 1'b0;
    st_d.wake_rst = 1'b0;
    st_d.irq_req = pin_req & irq_en;
    level_wake = |(irq_en & pin_low &
      {st_q.mcu_control[EXT_IRQ1_PIN_SENSE_LSB +: 2] == SENSE_LOW,
       st_q.mcu_control[EXT_IRQ0_PIN_SENSE_LSB +: 2] == SENSE_LOW});
    any_irq = (|(pin_req & irq_en)) | timer_irq;
    st_d.cycles = access_len(st_q.mcu_control[EXT_MEM_WAIT_STATE_BIT]);
    // register bus: one wait cycle, answer on the second
    if (bus_req) begin
      st_d.ack = 1'b1;
      st_d.resp = 2'h0;
      st_d.rdata = 32'h0;
      if (word_idx == MCU_CONTROL_OFS) begin
        if (write && byteenable[0]) begin
          st_d.mcu_control = writedata[7:0];
        end
        st_d.rdata = {24'h0, st_q.mcu_control};
      end else if (word_idx == IRQ_CONTROL_OFS) begin
        if (write && byteenable[0]) begin
          st_d.irq_control = writedata[7:0] & 8'h83;
        end
        st_d.rdata = {24'h0, st_q.irq_control};
      end else if (word_idx == CORE_STATUS_OFS) begin
        st_d.rdata = {24'h0, pin_low, st_q.irq_req, 2'h0, st_q.sst};
      end else begin
        st_d.resp = 2'h2; // unmapped: slave error
      end
    end
    // sleep control
    case (st_q.sst)
      ST_RUN: begin
        if (sleep_instr && st_q.mcu_control[SLEEP_ALLOW_BIT]) begin
          st_d.sst = st_q.mcu_control[SLEEP_SELECT_BIT] ? ST_PDOWN : ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (watchdog_reset) begin
          st_d.sst = ST_RUN;
          st_d.wake_rst = 1'b1;
        end else if (any_irq) begin
          st_d.sst = ST_RUN;
        end
      end
      ST_PDOWN: begin
        if (watchdog_reset) begin
          st_d.sst = ST_RUN;
          st_d.wake_rst = 1'b1;
        end else if (level_wake) begin
          st_d.sst = ST_START;
          st_d.start_cnt = 32'h0;
        end
      end
      ST_START: begin
        // oscillator start-up; the level must outlast the timeout
        if (watchdog_reset) begin
          st_d.sst = ST_RUN;
          st_d.wake_rst = 1'b1;
        end else if (!level_wake) begin
          st_d.sst = ST_PDOWN;
        end else if (st_q.start_cnt >= 32'(RESET_TIMEOUT - 1)) begin
          st_d.sst = ST_RUN;
        end else begin
          st_d.start_cnt = st_q.start_cnt + 32'h1;
        end
      end
      default: st_d.sst = ST_RUN;
    endcase
  end

  // ****************************************
  // registers; external reset also ends any sleep
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{mcu_control: MCU_CONTROL_RST, irq_control: IRQ_CONTROL_RST, rdata: 32'h0,
                ack: 1'b0, resp: 2'h0, sst: ST_RUN, start_cnt: 32'h0, irq_req: 2'h0,
                wake_rst: 1'b0, cycles: 3'(MEM_BASE_CYCLES)};
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign readdata = st_q.rdata;
  assign waitrequest = ~st_q.ack;
  assign response = st_q.resp;
  assign ext_mem_enable = st_q.mcu_control[EXT_MEM_ENABLE_BIT];
  assign ext_mem_wait_state = st_q.mcu_control[EXT_MEM_WAIT_STATE_BIT];
  assign mem_access_cycles = st_q.cycles;
  assign ext_irq_req = st_q.irq_req;
  assign cpu_halt = (st_q.sst != ST_RUN);
  assign osc_stop = (st_q.sst == ST_PDOWN);
  assign wake_reset = st_q.wake_rst;
  assign sleep_state = st_q.sst;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_sleep_cmd;
    (st_q.sst == ST_RUN) && sleep_instr;
  endsequence

  a_no_sleep_blocked: assert property ((s_sleep_cmd and !st_q.mcu_control[SLEEP_ALLOW_BIT])
    |=> st_q.sst == ST_RUN) else $error("slept without sleep_allow");
  a_sleep_mode_pick: assert property ((s_sleep_cmd and st_q.mcu_control[SLEEP_ALLOW_BIT])
    |=> st_q.sst == (st_q.mcu_control[SLEEP_SELECT_BIT] ? ST_PDOWN : ST_IDLE))
    else $error("wrong sleep mode");
  a_idle_fast_wake: assert property (st_q.sst == ST_IDLE && (|(pin_req & irq_en))
    |=> st_q.sst == ST_RUN) else $error("idle wake late");
  a_pdown_edge_only: assert property (st_q.sst == ST_PDOWN && !watchdog_reset
    && !(|(pin_low & irq_en)) |=> st_q.sst == ST_PDOWN)
    else $error("power-down left without level or reset");
  a_gate_irq: assert property (!irq_en[0] |=> !ext_irq_req[0])
    else $error("ungated request 0");
  a_level_follow: assert property (irq_en[0] && st_q.mcu_control[1:0] == SENSE_LOW
    && $stable(st_q.mcu_control) && $stable(st_q.irq_control)
    |=> ext_irq_req[0] == $past(pin_low[0], 2))
    else $error("level request not following pin");
  a_reserved_quiet: assert property (st_q.mcu_control[3:2] == SENSE_RSVD
    |=> !pin_req[1]) else $error("reserved code requested");
  a_wait_cycles: assert property (ext_mem_wait_state && $stable(ext_mem_wait_state)
    |-> mem_access_cycles == 3'(MEM_BASE_CYCLES + MEM_WAIT_CYCLES))
    else $error("wait state not added");
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");

endmodule : mcu_control_sleep

/* ext_irq_source.sv */
// model of the external interrupt sources on the two pins
module ext_irq_source (
  input wire logic clk,
  input wire logic [1:0] pull_low,
  output logic ext_irq0_pin,
  output logic ext_irq1_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // open-drain sources, pull-up when released
  // ****************************************
  initial ext_irq0_pin = 1'b1;
  initial ext_irq1_pin = 1'b1;
  // hold time is whatever the bench asks for
  always @(posedge clk) begin
    ext_irq0_pin <= !pull_low[0];
    ext_irq1_pin <= !pull_low[1];
  end
endmodule : ext_irq_source

/* testbench.sv */
// self-checking bench of the mcu control, sleep and external interrupt block
module testbench;
  import mcu_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RT = 4;
  localparam logic [7:0] A_MCU = 8'hD4;
  localparam logic [7:0] A_IRQ = 8'hD8;
  logic clk, nrst = 1'b0, read = 1'b0, write = 1'b0, sleep_instr = 1'b0;
  logic watchdog_reset = 1'b0, timer_irq = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [3:0] byteenable = 4'hF;
  logic [1:0] pull_low = 2'h0, response, rsp, ext_irq_req, sleep_state;
  logic ext_irq0_pin, ext_irq1_pin, waitrequest, ext_mem_enable, ext_mem_wait_state;
  logic cpu_halt, osc_stop, wake_reset;
  logic [2:0] mem_access_cycles;
  logic [31:0] seed = 32'd96;
  int failures = 0, tests_run = 0, hits0 = 0, hits1 = 0, wakes = 0;
  mcu_control_sleep #(.RESET_TIMEOUT(RT)) u_mcu_control_sleep (.clk(clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .sleep_instr(sleep_instr), .watchdog_reset(watchdog_reset),
    .timer_irq(timer_irq), .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
    .ext_mem_enable(ext_mem_enable), .ext_mem_wait_state(ext_mem_wait_state),
    .mem_access_cycles(mem_access_cycles), .ext_irq_req(ext_irq_req), .cpu_halt(cpu_halt),
    .osc_stop(osc_stop), .wake_reset(wake_reset), .sleep_state(sleep_state));
  ext_irq_source u_ext_irq_source (.clk(clk), .pull_low(pull_low),
    .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin));
  // ****************************************
  // clock, request counters, watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) begin
    if (ext_irq_req[0] === 1'b1) hits0++;
    if (ext_irq_req[1] === 1'b1) hits1++;
    if (wake_reset === 1'b1) wakes++;
  end
  initial begin
    #200000;
    failures++;
    $display("mismatch t=%0t timeout", $time);
    close_out();
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // requests seen for a four-cycle low pulse
  function automatic int exp_hits(logic [1:0] s, logic en);
    if (!en || s == SENSE_RSVD) return 0;
    return (s == SENSE_LOW) ? 4 : 1;
  endfunction : exp_hits
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    rsp = response;
    if (n >= 50) chk(1'b0, 1'b1, "bus answer");
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  task automatic sleep_now();
    @(posedge clk) sleep_instr <= 1'b1;
    @(posedge clk) sleep_instr <= 1'b0;
    w(3);
  endtask : sleep_now
  task automatic close_out();
    $display("counts: %0d compared, %0d failed", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] v;
    logic [1:0] s;
    w(4);
    nrst <= 1'b1;
    bus(0, A_MCU, 0); chk(rd, MCU_CONTROL_RST, "mcu reset");
    bus(0, 8'hE0, 0); chk({rd, rsp}, {32'h0, 2'b10}, "unmapped");
    bus(0, 8'hDC, 0); chk(rd, 32'h0, "status reset");
    $display("test reset done");
    repeat (6) begin
      v = 8'(xs());
      bus(1, A_MCU, v); bus(0, A_MCU, 0); chk(rd, {24'h0, v}, "mcu readback");
      w(2);
      chk(ext_mem_enable, v[7], "mem enable");
      chk(mem_access_cycles, v[6] ? 3'd4 : 3'd3, "mem cycles");
    end
    $display("test control done");
    for (int i = 0; i < 16; i++) begin
      v = 8'(xs());
      s = i[1:0];
      bus(1, A_MCU, {4'h0, s, s});
      bus(1, A_IRQ, {v[7], 5'h0, v[1:0]});
      hits0 = 0;
      hits1 = 0;
      @(posedge clk) pull_low[i[2]] <= 1'b1;
      w(4);
      pull_low[i[2]] <= 1'b0;
      w(8);
      chk(i[2] ? hits1 : hits0, exp_hits(s, v[7] & v[i[2]]), "pin requests");
      chk(i[2] ? hits0 : hits1, 0, "quiet pin");
    end
    $display("test sense done");
    bus(1, A_MCU, 8'h00); sleep_now(); chk(sleep_state, ST_RUN, "no allow");
    bus(1, A_MCU, 8'h20); sleep_now(); chk({sleep_state, cpu_halt}, {ST_IDLE, 1'b1}, "idle");
    @(posedge clk) timer_irq <= 1'b1;
    @(posedge clk) timer_irq <= 1'b0;
    w(2); chk(sleep_state, ST_RUN, "idle wake");
    bus(1, A_MCU, 8'h3A); bus(1, A_IRQ, 8'h83);
    sleep_now(); chk({sleep_state, osc_stop}, {ST_PDOWN, 1'b1}, "power-down");
    @(posedge clk) pull_low <= 2'h3;
    w(4);
    pull_low <= 2'h0;
    w(8); chk(sleep_state, ST_PDOWN, "edge no wake");
    wakes = 0;
    @(posedge clk) watchdog_reset <= 1'b1;
    @(posedge clk) watchdog_reset <= 1'b0;
    w(4); chk({sleep_state, 30'(wakes)}, {ST_RUN, 30'd1}, "reset wake");
    bus(1, A_MCU, 8'h30); sleep_now();
    @(posedge clk) pull_low[0] <= 1'b1;
    w(RT + 10); chk({sleep_state, osc_stop}, {ST_RUN, 1'b0}, "level wake");
    pull_low[0] <= 1'b0;
    $display("test sleep done");
    close_out();
  end
endmodule : testbench
